// ### logic/adpcm_decoder.sv
// adaptive differential pcm decoder: 4-bit codes in, 16-bit pcm samples out
// Summary of operation
// - one 4-bit code in, one 16-bit sample out
// - samples held as 16-bit signed pcm
// - delta is step times magnitude weights plus eighth
// - code sign bit chooses add or subtract
// - low three code bits are unsigned magnitude
// - index moves +8,+6,+4,+2 or -1 by magnitude
// - step from ascending constant table, 5 to 26565
// - step comes from index updated by previous code
module adpcm_decoder
  import adpcm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_code_valid,
  input wire logic [adpcm_pkg::ADPCM_CODE_W-1:0] i_code,
  output logic o_code_ready,
  output logic o_pcm_valid,
  output logic signed [adpcm_pkg::ADPCM_PCM_W-1:0] o_pcm
);
  import adpcm_pkg::*;

  adpcm_state_e state;
  adpcm_state_e next_state;
  logic [3:0] code;
  logic [6:0] index;
  logic [14:0] step;

  // the table read is registered, so the step arrives one cycle after the index changes, in time for the look state
  adpcm_step_rom u_rom (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_index(index),
    .o_step(step)
  );

  wire logic take = o_code_ready && i_code_valid;
  wire logic code_sign_bit = code[3];
  wire logic [2:0] magnitude = code[2:0];
  wire logic magnitude_high_bit = magnitude[2];
  wire logic magnitude_mid_bit = magnitude[1];
  wire logic magnitude_low_bit = magnitude[0];

  // step*(b2 + b1/2 + b0/4 + 1/8) computed as shifted partial sums, truncating each
  wire logic [16:0] part_high = magnitude_high_bit ? {2'b00, step} : 17'h00000;
  wire logic [16:0] part_mid = magnitude_mid_bit ? {3'b000, step[14:1]} : 17'h00000;
  wire logic [16:0] part_low = magnitude_low_bit ? {4'h0, step[14:2]} : 17'h00000;
  wire logic [16:0] part_eighth = {5'h00, step[14:3]};
  wire logic [16:0] delta = part_high + part_mid + part_low + part_eighth;

  wire logic signed [17:0] prev_wide = {{2{o_pcm[15]}}, o_pcm};
  wire logic signed [17:0] delta_wide = {1'b0, delta};
  wire logic signed [17:0] sum = code_sign_bit ? (prev_wide - delta_wide)
                                               : (prev_wide + delta_wide);
  wire logic sat_high = sum > 18'sh07fff;
  wire logic sat_low = sum < -18'sh08000;
  wire logic signed [15:0] next_pcm = sat_high ? 16'sh7fff :
                                      sat_low ? -16'sh8000 : sum[15:0];

  wire logic signed [4:0] adj = (magnitude == 3'h7) ? ADPCM_ADJ_M7 :
                                (magnitude == 3'h6) ? ADPCM_ADJ_M6 :
                                (magnitude == 3'h5) ? ADPCM_ADJ_M5 :
                                (magnitude == 3'h4) ? ADPCM_ADJ_M4 : ADPCM_ADJ_LOW;
  wire logic signed [8:0] index_sum = $signed({2'b00, index}) + 9'(adj);
  wire logic [6:0] next_index = (index_sum < 9'sh000) ? 7'h00 :
                                (index_sum > $signed({2'b00, ADPCM_IDX_LAST})) ?
                                ADPCM_IDX_LAST : index_sum[6:0];

  always_comb begin
    next_state = state;
    case (state)
      ADPCM_IDLE: begin
        if (take) begin
          next_state = ADPCM_LOOK;
        end
      end
      ADPCM_LOOK: begin
        next_state = ADPCM_CALC;
      end
      ADPCM_CALC: begin
        next_state = ADPCM_IDLE;
      end
      default: begin
        next_state = ADPCM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ADPCM_IDLE;
      code <= 4'h0;
    end else begin
      state <= next_state;
      if (take) begin
        code <= i_code;
      end
    end
  end

  // index changes only after the sample is built, so the next code sees the new step
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      index <= ADPCM_IDX_RESET;
      o_pcm <= ADPCM_PCM_RESET;
      o_pcm_valid <= 1'b0;
      o_code_ready <= 1'b0;
    end else begin
      o_pcm_valid <= (state == ADPCM_CALC);
      o_code_ready <= (next_state == ADPCM_IDLE);
      if (state == ADPCM_CALC) begin
        o_pcm <= next_pcm;
        index <= next_index;
      end
    end
  end

  property p_one_sample_per_code;
    @(posedge i_clk) disable iff (!i_reset_n)
      take |-> ##3 o_pcm_valid;
  endproperty
  a_one_sample_per_code: assert property (p_one_sample_per_code)
    else $error("code did not yield a sample three cycles later");

  property p_ready_drops;
    @(posedge i_clk) disable iff (!i_reset_n)
      take |=> !o_code_ready [*2];
  endproperty
  a_ready_drops: assert property (p_ready_drops)
    else $error("ready raised while a code is in flight");

  property p_pcm_stable;
    @(posedge i_clk) disable iff (!i_reset_n)
      !o_pcm_valid |-> $stable(o_pcm) || $past(state) == ADPCM_CALC;
  endproperty
  a_pcm_stable: assert property (p_pcm_stable)
    else $error("pcm changed without a sample strobe");

  property p_sign_dir;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == ADPCM_CALC && code_sign_bit) |=> $signed(o_pcm) <= $signed($past(o_pcm));
  endproperty
  a_sign_dir: assert property (p_sign_dir)
    else $error("negative code raised the output");

  property p_pos_dir;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == ADPCM_CALC && !code_sign_bit) |=> $signed(o_pcm) >= $signed($past(o_pcm));
  endproperty
  a_pos_dir: assert property (p_pos_dir)
    else $error("positive code lowered the output");

  property p_delta_min;
    @(posedge i_clk) disable iff (!i_reset_n)
      state == ADPCM_CALC |-> delta >= {5'h00, step[14:3]} && delta <= {step, 2'b00};
  endproperty
  a_delta_min: assert property (p_delta_min)
    else $error("scaled step out of range");

  property p_index_up7;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == ADPCM_CALC && magnitude == 3'h7 && index < 7'h50) |=>
        index == $past(index) + 7'h08;
  endproperty
  a_index_up7: assert property (p_index_up7)
    else $error("index did not rise by eight");

  property p_index_down;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == ADPCM_CALC && magnitude < 3'h4 && index != 7'h00) |=>
        index == $past(index) - 7'h01;
  endproperty
  a_index_down: assert property (p_index_down)
    else $error("index did not fall by one");

  property p_index_clamp;
    @(posedge i_clk) disable iff (!i_reset_n)
      index <= ADPCM_IDX_LAST;
  endproperty
  a_index_clamp: assert property (p_index_clamp)
    else $error("index left the table");

  property p_step_range;
    @(posedge i_clk) disable iff (!i_reset_n)
      state == ADPCM_CALC |-> step >= ADPCM_STEP_FIRST && step <= ADPCM_STEP_LAST;
  endproperty
  a_step_range: assert property (p_step_range)
    else $error("step outside table range");

  property p_step_follows;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == ADPCM_CALC && index == 7'h00) |-> step == ADPCM_STEP_FIRST;
  endproperty
  a_step_follows: assert property (p_step_follows)
    else $error("step does not match index");

  property p_ready_back;
    @(posedge i_clk) disable iff (!i_reset_n)
      take |-> ##3 o_code_ready;
  endproperty
  a_ready_back: assert property (p_ready_back)
    else $error("ready did not return with the sample");

  property p_index_up4;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == ADPCM_CALC && magnitude == 3'h4 && index < 7'h56) |=>
        index == $past(index) + 7'h02;
  endproperty
  a_index_up4: assert property (p_index_up4)
    else $error("index did not rise by two");

  property p_sat_high;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == ADPCM_CALC && sat_high) |=> $signed(o_pcm) == ADPCM_PCM_MAX;
  endproperty
  a_sat_high: assert property (p_sat_high)
    else $error("output not held at the positive limit");

  property p_sat_low;
    @(posedge i_clk) disable iff (!i_reset_n)
      (state == ADPCM_CALC && sat_low) |=> $signed(o_pcm) == ADPCM_PCM_MIN;
  endproperty
  a_sat_low: assert property (p_sat_low)
    else $error("output not held at the negative limit");
endmodule // adpcm_decoder

// ### include/adpcm_pkg.sv
// package of constants and types for the adaptive differential pcm decoder
package adpcm_pkg;
  localparam int unsigned ADPCM_CODE_W = 4;
  localparam int unsigned ADPCM_PCM_W = 16;
  localparam int unsigned ADPCM_IDX_W = 7;
  localparam int unsigned ADPCM_STEP_W = 15;
  // last entry of the 88-value step table
  localparam logic [6:0] ADPCM_IDX_LAST = 7'h57;
  localparam logic [6:0] ADPCM_IDX_RESET = 7'h00;
  localparam logic signed [15:0] ADPCM_PCM_RESET = 16'sh0000;
  localparam logic signed [16:0] ADPCM_PCM_MAX = 17'sh07fff;
  localparam logic signed [16:0] ADPCM_PCM_MIN = -17'sh08000;
  localparam logic [14:0] ADPCM_STEP_FIRST = 15'h0005;
  localparam logic [14:0] ADPCM_STEP_LAST = 15'h67c5;
  // signed index change for magnitudes 7, 6, 5, 4 and for 3 down to 0
  localparam logic signed [4:0] ADPCM_ADJ_M7 = 5'sh08;
  localparam logic signed [4:0] ADPCM_ADJ_M6 = 5'sh06;
  localparam logic signed [4:0] ADPCM_ADJ_M5 = 5'sh04;
  localparam logic signed [4:0] ADPCM_ADJ_M4 = 5'sh02;
  localparam logic signed [4:0] ADPCM_ADJ_LOW = -5'sh01;
  typedef enum logic [1:0] {
    ADPCM_IDLE = 2'b00,
    ADPCM_LOOK = 2'b01,
    ADPCM_CALC = 2'b11
  } adpcm_state_e;
endpackage

// ### logic/adpcm_step_rom.sv
// constant step-size table with a registered read port
module adpcm_step_rom
  import adpcm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [adpcm_pkg::ADPCM_IDX_W-1:0] i_index,
  output logic [adpcm_pkg::ADPCM_STEP_W-1:0] o_step
);
  import adpcm_pkg::*;

  localparam int unsigned N = 88;
  localparam logic [14:0] TABLE [N] = '{
    15'd5, 15'd6, 15'd7, 15'd8, 15'd9, 15'd10, 15'd11, 15'd12, 15'd14, 15'd15,
    15'd17, 15'd18, 15'd20, 15'd22, 15'd25, 15'd27, 15'd30, 15'd33, 15'd37, 15'd40,
    15'd44, 15'd49, 15'd54, 15'd59, 15'd65, 15'd72, 15'd79, 15'd87, 15'd95, 15'd105,
    15'd116, 15'd127, 15'd140, 15'd154, 15'd170, 15'd187, 15'd205, 15'd226, 15'd248,
    15'd273, 15'd301, 15'd331, 15'd364, 15'd400, 15'd440, 15'd485, 15'd533, 15'd586,
    15'd645, 15'd710, 15'd781, 15'd859, 15'd945, 15'd1039, 15'd1143, 15'd1258,
    15'd1384, 15'd1522, 15'd1674, 15'd1842, 15'd2026, 15'd2228, 15'd2451, 15'd2697,
    15'd2966, 15'd3263, 15'd3589, 15'd3948, 15'd4343, 15'd4777, 15'd5255, 15'd5781,
    15'd6359, 15'd6995, 15'd7694, 15'd8464, 15'd9310, 15'd10242, 15'd11266, 15'd12392,
    15'd13632, 15'd14995, 15'd16494, 15'd18144, 15'd19958, 15'd21954, 15'd24150,
    15'd26565
  };
  // out-of-range index reads the last entry, though the decoder never asks for one
  wire logic [14:0] next_step = (i_index > ADPCM_IDX_LAST) ? TABLE[N-1] : TABLE[i_index];

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_step <= ADPCM_STEP_FIRST;
    end else begin
      o_step <= next_step;
    end
  end
endmodule // adpcm_step_rom

// ### testbench/adpcm_src_model.sv
// source model: offers two packed codes per byte, upper nibble first
module adpcm_src_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire logic [7:0] i_byte,
  input wire logic i_gap,
  input wire logic i_ready,
  output logic o_valid,
  output logic [3:0] o_code,
  output logic o_empty
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] held;
  logic [1:0] left;
  logic took;
  assign o_empty = (left == 2'h0);
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      left <= 2'h0;
      took <= 1'b0;
    end else begin
      took <= o_valid && i_ready;
      if (i_load) begin
        held <= i_byte;
        left <= 2'h2;
      end else if (o_valid && i_ready) begin
        left <= left - 2'h1;
      end
    end
  end
  // an offer stands until taken; an idle code line flips so a stale code never looks fresh
  always @(negedge i_clk) begin
    o_valid <= !o_empty && ((o_valid && !took) || !i_gap);
    o_code <= (left == 2'h2) ? held[7:4] : ((left == 2'h1) ? held[3:0] : ~o_code);
  end
endmodule // adpcm_src_model

// ### testbench/tb_adpcm_decoder.sv
// self-checking bench: decoder fed by the packed-code source model
module tb_adpcm_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic load = 1'b0;
  logic gap = 1'b0;
  logic slow = 1'b0;
  logic [7:0] byte_in = 8'h00;
  logic valid, ready, pvalid, empty;
  logic [3:0] code;
  logic signed [15:0] pcm;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int ridx, pa;
  int exp_q[$];
  int cyc_q[$];
  // reference step table, indices 0..87
  int tbl[88] = '{5, 6, 7, 8, 9, 10, 11, 12, 14, 15, 17, 18, 20, 22, 25, 27, 30, 33, 37, 40,
    44, 49, 54, 59, 65, 72, 79, 87, 95, 105, 116, 127, 140, 154, 170, 187, 205, 226, 248, 273,
    301, 331, 364, 400, 440, 485, 533, 586, 645, 710, 781, 859, 945, 1039, 1143, 1258, 1384,
    1522, 1674, 1842, 2026, 2228, 2451, 2697, 2966, 3263, 3589, 3948, 4343, 4777, 5255, 5781,
    6359, 6995, 7694, 8464, 9310, 10242, 11266, 12392, 13632, 14995, 16494, 18144, 19958,
    21954, 24150, 26565};
  adpcm_decoder uut (.i_clk(clk), .i_reset_n(rst_n), .i_code_valid(valid), .i_code(code),
    .o_code_ready(ready), .o_pcm_valid(pvalid), .o_pcm(pcm));
  adpcm_src_model u_src (.i_clk(clk), .i_reset_n(rst_n), .i_load(load), .i_byte(byte_in),
    .i_gap(gap), .i_ready(ready), .o_valid(valid), .o_code(code), .o_empty(empty));
  function automatic int nxt(int p, int s, logic [3:0] c);
    int d;
    d = s >> 3;
    if (c[2]) d += s;
    if (c[1]) d += s >> 1;
    if (c[0]) d += s >> 2;
    p = c[3] ? p - d : p + d;
    return p > 32767 ? 32767 : (p < -32768 ? -32768 : p);
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", name, $signed(exp), $signed(got));
    end
  endtask
  task automatic end_of_test(input int hung);
    bad_count += hung;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always #25 clk = ~clk;
  always @(negedge clk) gap <= slow & cyc[1];
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst_n) begin
      pa = 0;
      ridx = 0;
      exp_q.delete();
      cyc_q.delete();
    end else if (valid && ready) begin
      pa = nxt(pa, tbl[ridx], code);
      ridx = ridx + (code[2] ? 2 * code[1:0] + 2 : -1);
      ridx = ridx < 0 ? 0 : (ridx > 87 ? 87 : ridx);
      exp_q.push_back(pa);
      cyc_q.push_back(cyc);
    end
  end
  always @(negedge clk) begin
    if (pvalid === 1'b1) begin
      if (exp_q.size() == 0) check("spurious_pcm_valid", 0, 1);
      else begin
        check("latency", 3, cyc - cyc_q.pop_front());
        check("ready_back", 1, ready);
        check("pcm", exp_q.pop_front(), pcm);
      end
    end
  end
  task automatic send(input logic [7:0] b);
    @(negedge clk);
    for (int n = 0; empty !== 1'b1; n++) begin
      if (n == 100) end_of_test(1);
      @(negedge clk);
    end
    load <= 1'b1;
    byte_in <= b;
    @(negedge clk);
    load <= 1'b0;
  endtask
  task automatic run(input string name, input logic [7:0] b[$]);
    foreach (b[i]) send(b[i]);
    for (int n = 0; exp_q.size() > 0 || empty !== 1'b1; n++) begin
      if (n == 200) end_of_test(1);
      @(negedge clk);
    end
    $display("test %s done", name);
  endtask
  // small codes keep the index pinned at its floor
  task automatic t_low();
    run("low_codes", {8'h01, 8'h23, 8'h89, 8'hab});
  endtask
  task automatic t_climb();
    run("climb", {8'h77, 8'h77, 8'h77, 8'h77, 8'h77, 8'h77});
  endtask
  task automatic t_slow();
    slow <= 1'b1;
    run("slow_mixed", {8'h32, 8'h45, 8'h67, 8'hcd, 8'hef, 8'h91, 8'hff});
    slow <= 1'b0;
  endtask
  // reset lands while a code is in flight; the half-done sample must vanish
  task automatic t_reset();
    send(8'h77);
    repeat (2) @(negedge clk);
    rst_n <= 1'b0;
    repeat (6) @(negedge clk);
    check("pcm_in_reset", 0, pcm);
    check("ready_in_reset", 0, ready);
    check("valid_in_reset", 0, pvalid);
    rst_n <= 1'b1;
    run("reset_mid_run", {8'h0b, 8'h3a});
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n <= 1'b1;
    t_low();
    t_climb();
    t_slow();
    t_reset();
    end_of_test(0);
  end
endmodule // tb_adpcm_decoder
